// ==== rtl/pam_pin_mux.sv ====
// Port A bits 6 to 12: dedicated function multiplexer.
// Assumes pins arrive unsynchronised; the link clock is sampled by mclk.
`timescale 1ns/1ps
`include "pam_consts.svh"

// Notes on behaviour
// - Cell octets come in on an eight-bit bus, bit 7 most significant, bit 0 least.
// - Every cell on the receive bus is exactly 53 octets.
// - A six-bit serial DMA user identifier goes out, bits 0 to 4 the sub-block code.
// - Bit 5 of that identifier is 0 for transmit and 1 for receive.
// - The identifier of each failed transfer is captured into the transfer error register.
// - Management port is full duplex: UART, transparent or general circuit interface.
// - The management interface is transmit, receive, sync and clock, some maybe unused.
// - In TDM nibble mode the nibble's least significant bit goes out on transmit line 0.
// - In TDM nibble mode receive line 0 carries the nibble's least significant bit.
// - In TDM serial mode the channel takes receive data one bit at a time on one input.
module pam_pin_mux
  import pam_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire logic [1:0]            sel_a12,
  input  wire logic [1:0]            sel_a11,
  input  wire logic [1:0]            sel_a10,
  input  wire logic [1:0]            sel_a9,
  input  wire logic [1:0]            sel_a8,
  input  wire logic [1:0]            sel_a7,
  input  wire logic [1:0]            sel_a6,
  input  wire logic [6:0]            gpio_out,
  input  wire logic [6:0]            gpio_dir_out,
  input  wire logic [6:0]            pin_in,
  input  wire logic [4:0]            utopia_rx_lo,
  input  wire logic                  rx_enb_n,
  input  wire pam_user_id_type       dma_user_id,
  input  wire logic                  dma_xfer_err,
  input  wire logic                  mgmt_tx_bit,
  input  wire logic                  tdm_tx_bit0,
  input  wire logic                  tdm_nibble_mode,
  input  wire logic                  link_clk,
  output logic [6:0]                 pin_out,
  output logic [6:0]                 pin_oe_n,
  output logic [6:0]                 gpio_in,
  output pam_octet_type              cell_octet,
  output logic                       cell_len_err,
  output pam_user_id_type            dma_err_user_id,
  output logic                       mgmt_rx_data,
  output logic                       mgmt_sync_in,
  output logic                       tdm_rx_line0,
  output logic                       tdm_serial_rx,
  output logic                       tdm_tx_frame_sync,
  output logic                       tdm_rx_frame_sync
);
  // Pin index 0 is bit 6, index 6 is bit 12
  logic [6:0][1:0] sel;
  logic [6:0]      pin_s;
  logic [6:0]      ded_oe;
  logic [6:0]      ded_out;
  logic [6:0]      pin_out_d;
  logic [6:0]      pin_out_q;
  logic [6:0]      pin_oe_n_d;
  logic [6:0]      pin_oe_n_q;
  logic [6:0]      gpio_in_q;
  logic [4:0]      lo_s;
  logic            enb_n_s;
  logic            lclk_s;
  logic            lclk_prev_q;
  logic            lclk_rise;

  assign sel = {sel_a12, sel_a11, sel_a10, sel_a9, sel_a8, sel_a7, sel_a6};

  // Pin levels and link clock cross into mclk before use
  pam_sync2 #(.W(14)) u_sync (
    .mclk (mclk),
    .srst (srst),
    .din  ({link_clk, rx_enb_n, utopia_rx_lo, pin_in}),
    .dout ({lclk_s, enb_n_s, lo_s, pin_s})
  );

  // Dedicated output function per pin: func2 of bits 10 to 12 is user id, func1/2 of bit 9 tx
  always_comb begin
    ded_oe  = '0;
    ded_out = '0;
    if (sel[6] == `PAM_SEL_FUNC2) begin
      ded_oe[6]  = 1'b1;
      ded_out[6] = dma_user_id.code[3];
    end
    if (sel[5] == `PAM_SEL_FUNC2) begin
      ded_oe[5]  = 1'b1;
      ded_out[5] = dma_user_id.code[4];
    end
    if (sel[4] == `PAM_SEL_FUNC2) begin
      ded_oe[4]  = 1'b1;
      ded_out[4] = dma_user_id.section;
    end
    if (sel[3] == `PAM_SEL_FUNC1) begin
      ded_oe[3]  = 1'b1;
      ded_out[3] = mgmt_tx_bit;
    end else if (sel[3] == `PAM_SEL_FUNC2) begin
      ded_oe[3]  = 1'b1;
      ded_out[3] = tdm_tx_bit0;
    end
  end

  // One function per pin; GPIO when none selected
  generate
    for (genvar i = 0; i < 7; i++) begin : g_pin
      always_comb begin
        if (sel[i] == `PAM_SEL_GPIO) begin
          pin_out_d[i]  = gpio_out[i];
          pin_oe_n_d[i] = ~gpio_dir_out[i];
        end else begin
          pin_out_d[i]  = ded_out[i];
          pin_oe_n_d[i] = ~ded_oe[i];
        end
      end
    end
  endgenerate

  // Pad outputs and GPIO input capture
  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_out_q  <= '0;
      pin_oe_n_q <= '1;
      gpio_in_q  <= '0;
    end else begin
      pin_out_q  <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
      gpio_in_q  <= pin_s;
    end
  end

  // Error capture of the user id on a failed transfer
  pam_user_id_type err_id_d;
  pam_user_id_type err_id_q;
  always_comb begin
    err_id_d = dma_xfer_err ? dma_user_id : err_id_q;
  end
  always_ff @(posedge mclk) begin
    if (srst) err_id_q <= '0;
    else      err_id_q <= err_id_d;
  end

  // Link clock edge from the synchronised sample
  assign lclk_rise = lclk_s & ~lclk_prev_q;

  // Serial/TDM inputs: taken on link clock rising edges
  logic       m_rx_d, m_sy_d, t_rx0_d, t_ser_d, t_ts_d, t_rs_d;
  logic       m_rx_q, m_sy_q, t_rx0_q, t_ser_q, t_ts_q, t_rs_q;
  always_comb begin
    m_rx_d  = m_rx_q;
    m_sy_d  = m_sy_q;
    t_rx0_d = t_rx0_q;
    t_ser_d = t_ser_q;
    t_ts_d  = t_ts_q;
    t_rs_d  = t_rs_q;
    if (lclk_rise) begin
      // Management port is full duplex; each input is independent
      if (sel[2] == `PAM_SEL_FUNC1) m_rx_d = pin_s[2];
      if (sel[1] == `PAM_SEL_FUNC1) m_sy_d = pin_s[1];
      if (sel[2] == `PAM_SEL_FUNC2) begin
        if (tdm_nibble_mode) t_rx0_d = pin_s[2];
        else                 t_ser_d = pin_s[2];
      end
      if (sel[1] == `PAM_SEL_FUNC2) t_ts_d = pin_s[1];
      if (sel[0] == `PAM_SEL_FUNC1) t_rs_d = pin_s[0];
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      lclk_prev_q <= 1'b0;
      m_rx_q      <= 1'b1;
      m_sy_q      <= 1'b0;
      t_rx0_q     <= 1'b0;
      t_ser_q     <= 1'b0;
      t_ts_q      <= 1'b0;
      t_rs_q      <= 1'b0;
    end else begin
      lclk_prev_q <= lclk_s;
      m_rx_q      <= m_rx_d;
      m_sy_q      <= m_sy_d;
      t_rx0_q     <= t_rx0_d;
      t_ser_q     <= t_ser_d;
      t_ts_q      <= t_ts_d;
      t_rs_q      <= t_rs_d;
    end
  end

  // Cell receive: octets taken on link clock rise while enable is low
  pam_cell_state_type st_q, st_d;
  logic [5:0]         cnt_q, cnt_d;
  pam_octet_type      oct_q, oct_d;
  logic               err_q, err_d;
  logic               take;
  logic [7:0]         octet;
  assign take  = lclk_rise & ~enb_n_s &
                 (sel[6] == `PAM_SEL_FUNC1) & (sel[5] == `PAM_SEL_FUNC1) &
                 (sel[4] == `PAM_SEL_FUNC1);
  assign octet = {lo_s, pin_s[6], pin_s[5], pin_s[4]};
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    oct_d = '0;
    err_d = 1'b0;
    case (st_q)
      PAM_CELL_IDLE, PAM_CELL_DONE: begin
        if (take) begin
          oct_d = '{valid: 1'b1, first: 1'b1, last: 1'b0, data: octet};
          cnt_d = 6'd1;
          st_d  = PAM_CELL_BODY;
        end else if (enb_n_s) begin
          st_d = PAM_CELL_IDLE;
        end
      end
      PAM_CELL_BODY: begin
        if (take) begin
          cnt_d = cnt_q + 6'd1;
          oct_d = '{valid: 1'b1, first: 1'b0,
                    last: (cnt_d == `PAM_CELL_OCTETS), data: octet};
          if (cnt_d == `PAM_CELL_OCTETS) st_d = PAM_CELL_DONE;
        end else if (lclk_rise & enb_n_s) begin
          err_d = 1'b1;
          st_d  = PAM_CELL_IDLE;
        end
      end
      default: st_d = PAM_CELL_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q  <= PAM_CELL_IDLE;
      cnt_q <= '0;
      oct_q <= '0;
      err_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      oct_q <= oct_d;
      err_q <= err_d;
    end
  end

  assign pin_out           = pin_out_q;
  assign pin_oe_n          = pin_oe_n_q;
  assign gpio_in           = gpio_in_q;
  assign cell_octet        = oct_q;
  assign cell_len_err      = err_q;
  assign dma_err_user_id   = err_id_q;
  assign mgmt_rx_data      = m_rx_q;
  assign mgmt_sync_in      = m_sy_q;
  assign tdm_rx_line0      = t_rx0_q;
  assign tdm_serial_rx     = t_ser_q;
  assign tdm_tx_frame_sync = t_ts_q;
  assign tdm_rx_frame_sync = t_rs_q;
endmodule

// ==== rtl/pam_consts.svh ====
// Constants for the port A low pin function multiplexer.
// Assumes inclusion by the package and the pin mux module only.
`ifndef PAM_CONSTS_SVH
`define PAM_CONSTS_SVH
`define PAM_CELL_OCTETS   6'd53
`define PAM_PIN_LO        6
`define PAM_PIN_HI        12
`define PAM_USER_ID_W     6
`define PAM_SECTION_BIT   5
`define PAM_SECT_TX       1'b0
`define PAM_SECT_RX       1'b1
`define PAM_NIB_W         4
`define PAM_SEL_GPIO      2'h0
`define PAM_SEL_FUNC1     2'h1
`define PAM_SEL_FUNC2     2'h2
`define PAM_SEL_FUNC3     2'h3
`endif

// ==== rtl/pam_pkg.sv ====
// Types for the port A low pin function multiplexer.
// Assumes pam_consts.svh sits beside it.
`include "pam_consts.svh"
package pam_pkg;
  typedef enum logic [1:0] {
    PAM_MGMT_UART  = 2'h0,
    PAM_MGMT_TRANS = 2'h1,
    PAM_MGMT_CIRCUIT = 2'h2
  } pam_mgmt_mode_type;

  typedef enum logic [2:0] {
    PAM_CELL_IDLE = 3'h1,
    PAM_CELL_BODY = 3'h2,
    PAM_CELL_DONE = 3'h4
  } pam_cell_state_type;

  // Serial DMA user identifier: section bit over sub-block code
  typedef struct packed {
    logic       section;
    logic [4:0] code;
  } pam_user_id_type;

  // One received cell octet with its framing marks
  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [7:0] data;
  } pam_octet_type;
endpackage

// ==== rtl/pam_sync2.sv ====
// Two flip-flop synchroniser for a bundle of pin levels.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/1ps
module pam_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // Next values: first stage feeds only the second
  always_comb begin
    meta_d = din;
    out_d  = meta_q;
  end

  // Register both stages
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_q <= '0;
      out_q  <= '0;
    end else begin
      meta_q <= meta_d;
      out_q  <= out_d;
    end
  end

  assign dout = out_q;
endmodule

// ==== testbench/pam_pin_mux_sva.sv ====
// Checker for the port A low pin multiplexer outputs.
// Assumes only the mclk domain ports of pam_pin_mux are watched.
`timescale 1ns/1ps
module pam_pin_mux_sva
  import pam_pkg::*;
(
  input wire logic            mclk,
  input wire logic            srst,
  input wire logic [1:0]      sel_a12,
  input wire logic [1:0]      sel_a10,
  input wire logic [1:0]      sel_a9,
  input wire logic [1:0]      sel_a8,
  input wire logic [6:0]      gpio_out,
  input wire logic [6:0]      gpio_dir_out,
  input wire pam_user_id_type dma_user_id,
  input wire logic            dma_xfer_err,
  input wire logic            mgmt_tx_bit,
  input wire logic            tdm_tx_bit0,
  input wire logic [6:0]      pin_out,
  input wire logic [6:0]      pin_oe_n,
  input wire pam_octet_type   cell_octet,
  input wire pam_user_id_type dma_err_user_id
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  // Octets seen so far in the current cell
  logic [5:0] n_d;
  logic [5:0] n_q;
  always_comb begin
    n_d = n_q;
    if (cell_octet.valid) n_d = cell_octet.first ? 6'h01 : n_q + 6'h01;
  end
  always_ff @(posedge mclk) begin
    n_q <= srst ? 6'h00 : n_d;
  end

  a_gpio_drive: assert property (
    sel_a9 == 2'h0 && gpio_dir_out[3] |=> !pin_oe_n[3] && pin_out[3] == $past(gpio_out[3]))
    else $error("gpio drive wrong on pin 9");
  a_input_hiz: assert property (
    sel_a8 != 2'h0 |=> pin_oe_n[2]) else $error("input pin 8 driven");
  a_id_code3: assert property (
    sel_a12 == 2'h2 |=> !pin_oe_n[6] && pin_out[6] == $past(dma_user_id.code[3]))
    else $error("user id code bit 3 wrong");
  a_id_section: assert property (
    sel_a10 == 2'h2 |=> !pin_oe_n[4] && pin_out[4] == $past(dma_user_id.section))
    else $error("user id section bit wrong");
  a_mgmt_tx: assert property (
    sel_a9 == 2'h1 |=> !pin_oe_n[3] && pin_out[3] == $past(mgmt_tx_bit))
    else $error("management transmit pin wrong");
  a_tdm_tx: assert property (
    sel_a9 == 2'h2 |=> !pin_oe_n[3] && pin_out[3] == $past(tdm_tx_bit0))
    else $error("tdm transmit line 0 wrong");
  a_err_capture: assert property (
    dma_xfer_err |=> dma_err_user_id == $past(dma_user_id)) else $error("id not captured");
  a_err_hold: assert property (
    !dma_xfer_err |=> $stable(dma_err_user_id)) else $error("captured id changed");
  a_octet_pulse: assert property (
    cell_octet.valid |=> !cell_octet.valid) else $error("octet valid too long");
  a_cell_last: assert property (
    cell_octet.valid && cell_octet.last |-> n_q == 6'h34) else $error("cell length wrong");
endmodule

bind pam_pin_mux pam_pin_mux_sva u_sva (
  .mclk(mclk), .srst(srst), .sel_a12(sel_a12), .sel_a10(sel_a10), .sel_a9(sel_a9),
  .sel_a8(sel_a8), .gpio_out(gpio_out), .gpio_dir_out(gpio_dir_out),
  .dma_user_id(dma_user_id), .dma_xfer_err(dma_xfer_err), .mgmt_tx_bit(mgmt_tx_bit),
  .tdm_tx_bit0(tdm_tx_bit0), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .cell_octet(cell_octet), .dma_err_user_id(dma_err_user_id)
);

// ==== testbench/pam_phy_model.sv ====
// Behavioural cell source and link clock on the receive side.
// Assumes the bench sets pad levels before each call of send.
`timescale 1ns/1ps
module pam_phy_model (
  output logic       link_clk,
  output logic       rx_enb_n,
  output logic [7:0] rx_byte
);
  // Link clock still and bus released outside frames
  initial begin
    link_clk = 1'b0;
    rx_enb_n = 1'b1;
    rx_byte = 8'hff;
  end

  // Sends n octets counting up from s, then idle periods with enable high
  task automatic send(input logic [7:0] s, input int n, input int idle);
    #7;
    for (int i = 0; i < n + idle; i++) begin
      rx_enb_n = (i >= n);
      rx_byte = (i < n) ? s + i[7:0] : ~rx_byte;
      #100 link_clk = 1'b1;
      #100 link_clk = 1'b0;
    end
    rx_enb_n = 1'b1;
    rx_byte = ~rx_byte;
  endtask
endmodule

// ==== testbench/port_a_low_pin_functions_test.sv ====
// Bench for pam_pin_mux: cells, DMA user id, serial pins and GPIO.
// Assumes pam_phy_model supplies the link clock and cell octets.
`timescale 1ns/1ps
module port_a_low_pin_functions_test
  import pam_pkg::*;
();
  logic            mclk = 1'b0, srst = 1'b1, err = 1'b0;
  logic            mtx = 1'b0, ttx = 1'b0, nib = 1'b0;
  logic [1:0]      sel [0:6] = '{default: 2'h0};
  logic [3:0]      pad = 4'h0;
  logic [6:0]      gout = 7'h00, gdir = 7'h00;
  pam_user_id_type uid = '0;
  wire logic       lclk, enb_n;
  wire logic [7:0] rxb;
  logic [6:0]      p_out, p_oe_n, g_in;
  pam_octet_type   oct;
  pam_user_id_type err_id;
  logic            len_err, m_rx, m_syn, t_rx0, t_srx, t_tsy, t_rsy;
  pam_octet_type   got [$];
  int              n_err = 0, mismatches = 0, n_tests = 0, cyc = 0;

  always #12.5 mclk = ~mclk;

  pam_phy_model u_phy (.link_clk(lclk), .rx_enb_n(enb_n), .rx_byte(rxb));
  pam_pin_mux uut (
    .mclk(mclk), .srst(srst), .sel_a12(sel[6]), .sel_a11(sel[5]), .sel_a10(sel[4]),
    .sel_a9(sel[3]), .sel_a8(sel[2]), .sel_a7(sel[1]), .sel_a6(sel[0]),
    .gpio_out(gout), .gpio_dir_out(gdir), .pin_in({rxb[2:0], pad}),
    .utopia_rx_lo(rxb[7:3]), .rx_enb_n(enb_n), .dma_user_id(uid), .dma_xfer_err(err),
    .mgmt_tx_bit(mtx), .tdm_tx_bit0(ttx), .tdm_nibble_mode(nib), .link_clk(lclk),
    .pin_out(p_out), .pin_oe_n(p_oe_n), .gpio_in(g_in), .cell_octet(oct),
    .cell_len_err(len_err), .dma_err_user_id(err_id), .mgmt_rx_data(m_rx),
    .mgmt_sync_in(m_syn), .tdm_rx_line0(t_rx0), .tdm_serial_rx(t_srx),
    .tdm_tx_frame_sync(t_tsy), .tdm_rx_frame_sync(t_rsy)
  );

  // Collects octets and length errors, and cuts a hang short
  always @(posedge mclk) begin
    cyc++;
    if (oct.valid === 1'b1) got.push_back(oct);
    if (len_err === 1'b1) n_err++;
    if (cyc == 8000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic t_cell();
    @(posedge mclk);
    for (int i = 4; i < 7; i++) sel[i] <= 2'h1;
    tick(8);
    u_phy.send(8'hc3, 53, 1);
    tick(4);
    chk("cell_size", got.size(), 53);
    chk("len_err_full", n_err, 0);
    foreach (got[i]) chk("octet", got[i], {1'b1, i == 0, i == 52, 8'hc3 + i[7:0]});
    got.delete();
    u_phy.send(8'h11, 5, 1);
    tick(4);
    chk("short_size", got.size(), 5);
    chk("len_err_short", n_err, 1);
    $display("t_cell done");
  endtask

  task automatic t_dma();
    pam_user_id_type ids [2] = '{'{1'b0, 5'h08}, '{1'b1, 5'h17}};
    foreach (ids[k]) begin
      @(posedge mclk);
      for (int i = 4; i < 7; i++) sel[i] <= 2'h2;
      uid <= ids[k];
      err <= 1'b1;
      @(posedge mclk);
      uid <= ~ids[k];
      err <= 1'b0;
      tick(2);
      #1;
      chk("id_pins", {p_out[6:4], p_oe_n[6:4]}, {~ids[k][3], ~ids[k][4], ~ids[k][5], 3'h0});
      chk("err_id", err_id, ids[k]);
    end
    $display("t_dma done");
  endtask

  task automatic t_mgmt();
    got.delete();
    for (int v = 0; v < 2; v++) begin
      @(posedge mclk);
      for (int i = 1; i < 7; i++) sel[i] <= (i < 4) ? 2'h1 : 2'h0;
      mtx <= v[0];
      pad <= {1'b0, v[0], ~v[0], 1'b0};
      u_phy.send(8'h3c, 1, 0);
      tick(4);
      #1;
      chk("mgmt", {p_out[3], p_oe_n[3:1], m_rx, m_syn}, {v[0], 3'h3, v[0], ~v[0]});
    end
    chk("refused_cells", got.size(), 0);
    $display("t_mgmt done");
  endtask

  task automatic t_tdm();
    for (int v = 0; v < 4; v++) begin
      @(posedge mclk);
      for (int i = 0; i < 4; i++) sel[i] <= (i == 0) ? 2'h1 : 2'h2;
      ttx <= v[0];
      nib <= v[1];
      pad <= {1'b0, v[0], v[0], ~v[0]};
      u_phy.send(8'h00, 1, 0);
      tick(4);
      #1;
      chk("tdm_tx", p_out[3], v[0]);
      chk("tdm_syncs", {t_tsy, t_rsy}, {v[0], ~v[0]});
      if (v[1]) chk("nib_rx", t_rx0, v[0]);
      else chk("ser_rx", t_srx, v[0]);
    end
    $display("t_tdm done");
  endtask

  task automatic t_gpio();
    @(posedge mclk);
    foreach (sel[i]) sel[i] <= 2'h0;
    gout <= 7'h58;
    gdir <= 7'h78;
    pad <= 4'h9;
    tick(5);
    #1;
    chk("gpio_oe", p_oe_n, 7'h07);
    chk("gpio_out", p_out[6:3], 4'hb);
    chk("gpio_in", g_in[3:0], 4'h9);
    $display("t_gpio done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    tick(3);
    #1;
    chk("reset", {p_oe_n, p_out, m_rx, err_id}, {7'h7f, 7'h00, 1'b1, 6'h00});
    @(posedge mclk);
    srst <= 1'b0;
    tick(3);
    t_cell();
    t_dma();
    t_mgmt();
    t_tdm();
    t_gpio();
    final_report();
  end
endmodule
